// ---- logic/wsc_pkg.sv ----
// Constants for the watchdog, reset and sleep control block.
// Assumes a single 50 MHz pclk; the slow oscillator is an enable pulse.
package wsc_pkg;

    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [5:0] CLK_MODE_IDX  = 6'h03;
    localparam logic [5:0] MISC_CTRL_IDX = 6'h08;
    localparam logic [5:0] STATUS_IDX    = 6'h09;

    // ==========================================================
    // Clock mode register fields
    localparam int CM_PIN_FN_B  = 0;
    localparam int CM_WDT_EN_B  = 1;
    localparam int CM_SLOW_EN_B = 2;
    localparam int CM_TYPE_B    = 3;
    localparam int CM_FAST_EN_B = 4;
    localparam int CM_SEL_LSB   = 5;
    localparam logic [7:0] CLK_MODE_RST = 8'hf6;
    localparam logic [1:0] WDT_SEL_RST  = 2'h0;

    // ==========================================================
    // Status register fields and codes
    localparam int ST_MODE_LSB  = 0;
    localparam int ST_CAUSE_LSB = 2;
    localparam logic [2:0] CAUSE_POR = 3'h1;
    localparam logic [2:0] CAUSE_WDT = 3'h2;
    localparam logic [2:0] CAUSE_EXT = 3'h4;
    localparam logic [1:0] MODE_CODE_RUN   = 2'h0;
    localparam logic [1:0] MODE_CODE_LIGHT = 2'h1;
    localparam logic [1:0] MODE_CODE_DEEP  = 2'h2;

    // ==========================================================
    // Timing, in slow-oscillator periods and pclk cycles
    localparam int WDT_CW      = 19;
    localparam int WDT_P0      = 8192;
    localparam int WDT_P1      = 16384;
    localparam int WDT_P2      = 65536;
    localparam int WDT_P3      = 262144;
    localparam int SLOW_DIV_DEF = 16;
    localparam logic [7:0] RST_HOLD_CYC = 8'h10;

    typedef enum logic [1:0] {WSC_RUN, WSC_LIGHT, WSC_DEEP} wsc_mode_e;

endpackage : wsc_pkg

// ---- logic/wsc_wdt_if.sv ----
// Link between the control top and the watchdog counter.
// Assumes both ends sit on the same pclk.
`timescale 1ns/1ns
interface wsc_wdt_if #(parameter int CW = 19);
    logic          tick;
    logic          clear;
    logic          enable;
    logic [1:0]    sel;
    logic          timeout;
    logic [CW-1:0] count;

    modport ctl (output tick, clear, enable, sel, input timeout, count);
    modport wdt (input tick, clear, enable, sel, output timeout, count);
endinterface : wsc_wdt_if

// ---- logic/wsc_wdt.sv ----
// Watchdog counter advanced by slow-oscillator enable pulses.
// Assumes the tick is already gated off while that oscillator is stopped.
`timescale 1ns/1ns
module wsc_wdt
    import wsc_pkg::*;
#(
    parameter int CW = WDT_CW,
    parameter int P0 = WDT_P0,
    parameter int P1 = WDT_P1,
    parameter int P2 = WDT_P2,
    parameter int P3 = WDT_P3
)(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control link
    wsc_wdt_if.wdt   wif
);
    logic [CW-1:0] count_r;
    logic [CW-1:0] limit;
    logic          timeout_r;

    // ==========================================================
    // Timeout selection
    always_comb
    begin
        unique case (wif.sel)
            2'h0: limit = CW'(P0);
            2'h1: limit = CW'(P1);
            2'h2: limit = CW'(P2);
            2'h3: limit = CW'(P3);
        endcase
    end

    // ==========================================================
    // Counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_r   <= '0;
            timeout_r <= 1'b0;
        end
        else if (wif.clear)
        begin
            count_r   <= '0;
            timeout_r <= 1'b0;
        end
        else if (wif.enable && wif.tick)
        begin
            if (count_r + CW'(1) >= limit)
            begin
                count_r   <= '0;
                timeout_r <= 1'b1;
            end
            else
            begin
                count_r   <= count_r + CW'(1);
                timeout_r <= 1'b0;
            end
        end
        else
            timeout_r <= 1'b0;
    end

    assign wif.count   = count_r;
    assign wif.timeout = timeout_r;

    // ==========================================================
    // Checks
    a_wdt_clear_zero: assert property (@(posedge pclk) disable iff (!presetn)
        wif.clear |=> (count_r == '0) && !timeout_r)
        else $error("watchdog count not zero after clear");
    a_wdt_idle_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !wif.clear && !(wif.tick && wif.enable) |=> $stable(count_r))
        else $error("watchdog advanced without a slow tick");

endmodule : wsc_wdt

// ---- logic/wsc_top.sv ----
// Watchdog, reset generation and sleep-mode control with an APB slave.
// Assumes core strobes, pins and wake sources are synchronous to pclk.
`timescale 1ns/1ns

module wsc_top
    import wsc_pkg::*;
#(
    parameter int NP       = 16,
    parameter int NT       = 6,
    parameter int SLOW_DIV = SLOW_DIV_DEF,
    parameter int WDT_T0   = WDT_P0,
    parameter int WDT_T1   = WDT_P1,
    parameter int WDT_T2   = WDT_P2,
    parameter int WDT_T3   = WDT_P3
)(
    // Clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // APB slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    // Core instruction strobes
    input  wire logic          clr_watchdog_instr,
    input  wire logic          light_sleep_instr,
    input  wire logic          deep_sleep_instr,
    // Shared reset pin
    input  wire logic          ext_reset_n_pin,
    // Wake sources
    input  wire logic [NP-1:0] pin_in,
    input  wire logic [NP-1:0] pin_direction_ctrl,
    input  wire logic [NP-1:0] pin_digital_input_enable,
    input  wire logic [NT-1:0] timer_match,
    input  wire logic [NT-1:0] timer_on_sysclk,
    input  wire logic [NT-1:0] timer_osc_on,
    input  wire logic          comparator_ctrl_wake,
    input  wire logic          comparator_select_wake,
    input  wire logic          comparator_event,
    // Reset and power controls
    output logic               core_reset,
    output logic               sram_clear,
    output logic               sys_clk_en,
    output logic               prog_mem_on,
    output logic               fast_osc_en,
    output logic               slow_osc_en,
    output logic [2:0]         sys_clk_sel,
    output logic               clock_type,
    output logic               ext_reset_mode,
    output logic [NT-1:0]      timer_run,
    output logic               resume_pulse
);
    // ==========================================================
    // Declarations
    logic [7:0]    clk_mode_r;
    logic [1:0]    wdt_sel_r;
    logic [2:0]    cause_r;
    logic [7:0]    rst_cnt_r;
    logic [7:0]    rst_cnt_nxt;
    logic          core_reset_r;
    logic          sram_clear_r;
    logic [31:0]   prdata_r;
    logic          pready_r;
    logic          pslverr_r;
    logic [NP-1:0] pin_q_r;
    logic [NP-1:0] toggle;
    logic [15:0]   slow_cnt_r;
    logic          slow_tick_r;
    wsc_mode_e     mode_r;
    wsc_mode_e     mode_nxt;
    logic          sys_clk_en_r;
    logic          prog_mem_on_r;
    logic          fast_osc_en_r;
    logic          slow_osc_en_r;
    logic [NT-1:0] timer_run_r;
    logic          resume_r;
    logic          ext_low;
    logic          rst_evt;
    logic          light_wake;
    logic          deep_wake;
    logic          hit_cm;
    logic          hit_misc;
    logic          hit_stat;
    logic          addr_ok;
    logic          wr_en;
    logic [1:0]    mode_code;

    wsc_wdt_if #(.CW(WDT_CW)) wif ();

    // ==========================================================
    // Watchdog
    assign wif.tick   = slow_tick_r;
    // Held clear through the reset hold, or a short timeout re-fires
    assign wif.clear  = clr_watchdog_instr | rst_evt | core_reset_r;
    assign wif.enable = clk_mode_r[CM_WDT_EN_B];
    assign wif.sel    = wdt_sel_r;

    wsc_wdt #(
        .CW (WDT_CW),
        .P0 (WDT_T0),
        .P1 (WDT_T1),
        .P2 (WDT_T2),
        .P3 (WDT_T3)
    ) u_wdt (
        .pclk    (pclk),
        .presetn (presetn),
        .wif     (wif)
    );

    // ==========================================================
    // Slow oscillator stand-in: enable pulse while it runs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            slow_cnt_r  <= 16'h0000;
            slow_tick_r <= 1'b0;
        end
        else if (!slow_osc_en_r)
        begin
            slow_cnt_r  <= 16'h0000;
            slow_tick_r <= 1'b0;
        end
        else if (slow_cnt_r == 16'(SLOW_DIV - 1))
        begin
            slow_cnt_r  <= 16'h0000;
            slow_tick_r <= 1'b1;
        end
        else
        begin
            slow_cnt_r  <= slow_cnt_r + 16'h0001;
            slow_tick_r <= 1'b0;
        end
    end

    // ==========================================================
    // Reset generation
    // Pin is only a reset source once software has made it one.
    assign ext_low = clk_mode_r[CM_PIN_FN_B] & ~ext_reset_n_pin;
    assign rst_evt = ext_low | wif.timeout;

    always_comb
    begin
        if (rst_evt)
            rst_cnt_nxt = RST_HOLD_CYC;
        else if (rst_cnt_r != 8'h00)
            rst_cnt_nxt = rst_cnt_r - 8'h01;
        else
            rst_cnt_nxt = 8'h00;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rst_cnt_r    <= RST_HOLD_CYC;
            core_reset_r <= 1'b1;
            sram_clear_r <= 1'b1;
        end
        else
        begin
            rst_cnt_r    <= rst_cnt_nxt;
            core_reset_r <= (rst_cnt_nxt != 8'h00);
            // Only power-on wipes memory; later resets never do
            sram_clear_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cause_r <= CAUSE_POR;
        else if (wif.timeout)
            cause_r <= CAUSE_WDT;
        else if (ext_low)
            cause_r <= CAUSE_EXT;
    end

    // ==========================================================
    // Registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            clk_mode_r <= CLK_MODE_RST;
            wdt_sel_r  <= WDT_SEL_RST;
        end
        else if (rst_evt)
        begin
            // Pin function survives so a held pin keeps reset asserted
            clk_mode_r <= {CLK_MODE_RST[7:1], clk_mode_r[CM_PIN_FN_B]};
            wdt_sel_r  <= WDT_SEL_RST;
        end
        else if (wr_en && hit_cm)
            clk_mode_r <= pwdata[7:0];
        else if (wr_en && hit_misc)
            wdt_sel_r  <= pwdata[1:0];
    end

    // ==========================================================
    // APB slave, zero wait states, data latched in setup
    assign addr_ok  = (paddr[1:0] == 2'h0);
    assign hit_cm   = addr_ok && (paddr[7:2] == CLK_MODE_IDX);
    assign hit_misc = addr_ok && (paddr[7:2] == MISC_CTRL_IDX);
    assign hit_stat = addr_ok && (paddr[7:2] == STATUS_IDX);
    assign wr_en    = psel && penable && pwrite && pready_r;

    always_comb
    begin
        unique case (mode_r)
            WSC_RUN:   mode_code = MODE_CODE_RUN;
            WSC_LIGHT: mode_code = MODE_CODE_LIGHT;
            WSC_DEEP:  mode_code = MODE_CODE_DEEP;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r <= 1'b1;
            if (psel && !penable)
            begin
                pslverr_r <= !(hit_cm || hit_misc || hit_stat);
                prdata_r  <= 32'h0000_0000;
                // Timeout field is write-only and reads back as zero
                if (!pwrite && hit_cm)
                    prdata_r[7:0] <= clk_mode_r;
                else if (!pwrite && hit_stat)
                begin
                    prdata_r[ST_MODE_LSB +: 2]  <= mode_code;
                    prdata_r[ST_CAUSE_LSB +: 3] <= cause_r;
                end
            end
            else if (!psel)
                pslverr_r <= 1'b0;
        end
    end

    // ==========================================================
    // Wake detection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pin_q_r <= '0;
        else
            pin_q_r <= pin_in;
    end

    assign toggle = pin_in ^ pin_q_r;
    assign light_wake =
        |(toggle & pin_direction_ctrl & pin_digital_input_enable)
        | |(timer_match & ~timer_on_sysclk)
        | (comparator_ctrl_wake & comparator_select_wake
           & comparator_event);
    assign deep_wake = |(toggle & pin_digital_input_enable);

    // ==========================================================
    // Sleep mode machine
    always_comb
    begin
        mode_nxt = mode_r;
        if (rst_evt || core_reset_r)
            mode_nxt = WSC_RUN;
        else
        begin
            unique case (mode_r)
                WSC_RUN:
                begin
                    if (deep_sleep_instr)
                        mode_nxt = WSC_DEEP;
                    else if (light_sleep_instr)
                        mode_nxt = WSC_LIGHT;
                end
                WSC_LIGHT:
                    if (light_wake)
                        mode_nxt = WSC_RUN;
                WSC_DEEP:
                    if (deep_wake)
                        mode_nxt = WSC_RUN;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode_r <= WSC_RUN;
        else
            mode_r <= mode_nxt;
    end

    // Resume strobe: core continues after the sleep instruction
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            resume_r <= 1'b0;
        else
            resume_r <= (mode_r != WSC_RUN) && (mode_nxt == WSC_RUN)
                        && !rst_evt;
    end

    // ==========================================================
    // Clock and power outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sys_clk_en_r  <= 1'b1;
            prog_mem_on_r <= 1'b1;
            fast_osc_en_r <= CLK_MODE_RST[CM_FAST_EN_B];
            slow_osc_en_r <= CLK_MODE_RST[CM_SLOW_EN_B];
        end
        else
        begin
            sys_clk_en_r  <= (mode_nxt == WSC_RUN);
            prog_mem_on_r <= (mode_nxt == WSC_RUN);
            fast_osc_en_r <= (mode_nxt != WSC_DEEP)
                             && clk_mode_r[CM_FAST_EN_B];
            // Forced on in light sleep so the core can wake on it
            slow_osc_en_r <= (mode_nxt == WSC_LIGHT)
                             || ((mode_nxt == WSC_RUN)
                                 && clk_mode_r[CM_SLOW_EN_B]);
        end
    end

    for (genvar i = 0; i < NT; i++)
    begin : g_timer
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                timer_run_r[i] <= 1'b1;
            else
                timer_run_r[i] <= (mode_nxt == WSC_RUN)
                    || ((mode_nxt == WSC_LIGHT) && !timer_on_sysclk[i]
                        && timer_osc_on[i]);
        end
    end

    assign prdata         = prdata_r;
    assign pready         = pready_r;
    assign pslverr        = pslverr_r;
    assign core_reset     = core_reset_r;
    assign sram_clear     = sram_clear_r;
    assign sys_clk_en     = sys_clk_en_r;
    assign prog_mem_on    = prog_mem_on_r;
    assign fast_osc_en    = fast_osc_en_r;
    assign slow_osc_en    = slow_osc_en_r;
    assign sys_clk_sel    = clk_mode_r[CM_SEL_LSB +: 3];
    assign clock_type     = clk_mode_r[CM_TYPE_B];
    assign ext_reset_mode = clk_mode_r[CM_PIN_FN_B];
    assign timer_run      = timer_run_r;
    assign resume_pulse   = resume_r;

    // ==========================================================
    // Checks
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_enter_light;
        (mode_r == WSC_RUN) && !rst_evt && !core_reset_r
        && light_sleep_instr && !deep_sleep_instr;
    endsequence
    sequence s_enter_deep;
        (mode_r == WSC_RUN) && !rst_evt && !core_reset_r && deep_sleep_instr;
    endsequence
    sequence s_light_wake;
        (mode_r == WSC_LIGHT) && light_wake && !rst_evt && !core_reset_r;
    endsequence

    a_light_gate_clk: assert property (s_enter_light |=>
        !sys_clk_en_r && !prog_mem_on_r && (mode_r == WSC_LIGHT))
        else $error("light sleep left system clock running");
    a_deep_osc_off: assert property (s_enter_deep |=>
        !fast_osc_en_r && !slow_osc_en_r && !prog_mem_on_r)
        else $error("deep sleep left an oscillator running");
    a_light_slow_on: assert property ((mode_r == WSC_LIGHT) |->
        slow_osc_en_r)
        else $error("slow oscillator off in light sleep");
    a_deep_stay: assert property ((mode_r == WSC_DEEP) && !deep_wake
        && !rst_evt |=> (mode_r == WSC_DEEP))
        else $error("deep sleep left without pin toggle");
    a_wake_resume: assert property (s_light_wake |=>
        (mode_r == WSC_RUN) && resume_r && !core_reset_r)
        else $error("wake did not resume without reset");
    a_ext_rst_hold: assert property (ext_low |=>
        (core_reset_r && (cause_r == CAUSE_EXT)) [*2])
        else $error("low reset pin did not hold reset");
    a_wdt_rst_cause: assert property (wif.timeout |=>
        core_reset_r && (cause_r == CAUSE_WDT) && !sram_clear_r)
        else $error("watchdog timeout did not reset core");
    a_rst_defaults: assert property (rst_evt |=>
        (clk_mode_r[7:1] == CLK_MODE_RST[7:1]) && (wdt_sel_r == WDT_SEL_RST)
        && (mode_r == WSC_RUN))
        else $error("reset did not restore defaults");
    a_mem_kept: assert property (rst_evt ##1 1'b1 |-> !sram_clear_r)
        else $error("memory cleared by a warm reset");

endmodule : wsc_top

// ---- tb/tb.sv ----
// Bench for the watchdog, reset and sleep control block.
// Assumes zero-wait APB and a warm reset hold of 16 cycles.
`timescale 1ns/1ns
module tb;
    import wsc_pkg::*;
    // ==========================================
    // Signals
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        clr_watchdog_instr, light_sleep_instr, deep_sleep_instr;
    logic        ext_reset_n_pin, comparator_event, seen, err;
    logic        comparator_ctrl_wake, comparator_select_wake;
    logic [15:0] pin_in, pin_direction_ctrl, pin_digital_input_enable;
    logic [5:0]  timer_match, timer_on_sysclk, timer_osc_on, timer_run;
    logic        core_reset, sram_clear, sys_clk_en, prog_mem_on;
    logic        fast_osc_en, slow_osc_en, clock_type, ext_reset_mode;
    logic        resume_pulse;
    logic [2:0]  sys_clk_sel;
    int          mismatches = 0;
    int          checked = 0;
    int          n;

    // Short counts keep the run small: timeout = ticks * 2 cycles
    wsc_top #(.SLOW_DIV(2), .WDT_T0(8), .WDT_T1(16), .WDT_T2(32),
        .WDT_T3(64)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .clr_watchdog_instr,
        .light_sleep_instr, .deep_sleep_instr, .ext_reset_n_pin, .pin_in,
        .pin_direction_ctrl, .pin_digital_input_enable, .timer_match,
        .timer_on_sysclk, .timer_osc_on, .comparator_ctrl_wake,
        .comparator_select_wake, .comparator_event, .core_reset,
        .sram_clear, .sys_clk_en, .prog_mem_on, .fast_osc_en, .slow_osc_en,
        .sys_clk_sel, .clock_type, .ext_reset_mode, .timer_run,
        .resume_pulse);

    always #10 pclk = ~pclk;

    // ==========================================
    // Shared tasks
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wait_cr(input logic lvl);
        n = 0;
        while (core_reset !== lvl && n < 4000)
        begin
            @(negedge pclk);
            n++;
        end
        chk("reset wait", n < 4000, 1);
    endtask : wait_cr

    task clr;
        @(posedge pclk) clr_watchdog_instr <= 1'b1;
        @(posedge pclk) clr_watchdog_instr <= 1'b0;
    endtask : clr

    task sleep(input logic deep);
        @(posedge pclk);
        if (deep) deep_sleep_instr <= 1'b1; else light_sleep_instr <= 1'b1;
        @(posedge pclk);
        deep_sleep_instr <= 1'b0;
        light_sleep_instr <= 1'b0;
        @(negedge pclk);
    endtask : sleep

    // Kind 0 pin toggle, 1 free timer, 2 comparator, 3 sysclk timer
    task fire(input int k, input logic e);
        @(posedge pclk);
        case (k)
            0: pin_in <= ~pin_in;
            1: timer_match <= 6'h04;
            2: comparator_event <= 1'b1;
            default: timer_match <= 6'h01;
        endcase
        @(posedge pclk);
        timer_match <= 6'h00;
        comparator_event <= 1'b0;
        seen = 1'b0;
        repeat (4) @(negedge pclk) seen |= resume_pulse;
        chk("wake", seen, e);
        chk("sysclk", sys_clk_en, e);
    endtask : fire

    // ==========================================
    // Scenarios
    task t_reset;
        @(negedge pclk);
        chk("core_reset", core_reset, 1);
        chk("sel", sys_clk_sel, 3'h7);
        chk("type", clock_type, 0);
        apb(0, 8'h0c, 0);
        chk("clock_mode", rd, 32'hf6);
        apb(0, 8'h20, 0);
        chk("misc", rd, 0);
        apb(0, 8'h3c, 0);
        chk("unmapped", err, 1);
        $display("reset test done");
    endtask : t_reset

    task t_wdt;
        for (int s = 0; s < 4; s++)
        begin
            wait_cr(0);
            apb(1, 8'h20, s);
            clr();
            wait_cr(1);
            chk("span", n >= (16 << s) - 4 && n <= (16 << s) + 4, 1);
            chk("sram", sram_clear, 0);
        end
        wait_cr(0);
        apb(0, 8'h24, 0);
        chk("cause", rd, {27'h0, CAUSE_WDT, MODE_CODE_RUN});
        repeat (12)
        begin
            repeat (6) @(negedge pclk);
            chk("cleared", core_reset, 0);
            clr();
        end
        apb(1, 8'h0c, 32'hf4);
        repeat (300) @(negedge pclk);
        chk("wdt off", core_reset, 0);
        apb(1, 8'h0c, 32'hf2);
        repeat (300) @(negedge pclk);
        chk("slow off", core_reset, 0);
        chk("slow_en", slow_osc_en, 0);
        apb(1, 8'h0c, 32'hf4);
        $display("watchdog test done");
    endtask : t_wdt

    task t_sleep;
        timer_on_sysclk <= 6'h01;
        timer_osc_on <= 6'h3d;
        sleep(0);
        chk("prog", prog_mem_on, 0);
        chk("slow", slow_osc_en, 1);
        chk("fast", fast_osc_en, 1);
        chk("timers", timer_run, 6'h3c);
        @(posedge pclk) pin_digital_input_enable <= 16'h0000;
        fire(0, 0);
        @(posedge pclk) pin_digital_input_enable <= 16'hffff;
        fire(2, 0);
        fire(3, 0);
        fire(1, 1);
        @(posedge pclk) comparator_select_wake <= 1'b1;
        sleep(0);
        fire(2, 1);
        @(posedge pclk) comparator_ctrl_wake <= 1'b0;
        sleep(1);
        chk("deep fast", fast_osc_en, 0);
        chk("deep slow", slow_osc_en, 0);
        fire(1, 0);
        fire(2, 0);
        fire(0, 1);
        chk("no reset", core_reset, 0);
        apb(0, 8'h0c, 0);
        chk("kept", rd, 32'hf4);
        $display("sleep test done");
    endtask : t_sleep

    task t_pin;
        apb(1, 8'h0c, 32'hf5);
        @(negedge pclk);
        chk("pin mode", ext_reset_mode, 1);
        @(posedge pclk) ext_reset_n_pin <= 1'b0;
        repeat (3) @(negedge pclk);
        chk("pin rst", core_reset, 1);
        chk("pin sram", sram_clear, 0);
        @(posedge pclk) ext_reset_n_pin <= 1'b1;
        wait_cr(0);
        apb(0, 8'h24, 0);
        chk("cause", rd, {27'h0, CAUSE_EXT, MODE_CODE_RUN});
        apb(0, 8'h0c, 0);
        chk("defaults", rd, 32'hf7);
        $display("pin reset test done");
    endtask : t_pin

    task results;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    // ==========================================
    // Sequence and watchdog
    initial
    begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {clr_watchdog_instr, light_sleep_instr, deep_sleep_instr} = '0;
        {timer_match, timer_on_sysclk, timer_osc_on} = '0;
        {comparator_ctrl_wake, comparator_select_wake} = 2'h2;
        {comparator_event, pin_in} = '0;
        ext_reset_n_pin = 1'b1;
        pin_direction_ctrl = 16'hffff;
        pin_digital_input_enable = 16'hffff;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_wdt();
        t_sleep();
        t_pin();
        results();
    end

    initial
    begin
        #300000;
        mismatches++;
        results();
    end
endmodule : tb
